// ===== psfc_core.sv
/*
 * Power switch fault controller with AXI4-Lite register slave.
 * Assumes comparator inputs arrive asynchronously as pins and that
 * open select and enable pins are pulled high outside this block.
 */
// Notes on behaviour
// - Continuous limiting until startup timeout expires
// - Select 00 latch, 01 retry, else continuous
// - Open select pins read high, continuous
// - Severe overload drops both transistors, restarts
// - Severe-overload off time at least 420us
// - Latchoff latches on overcurrent past blanking
// - Hold timer runs during overcurrent outside continuous mode, clears otherwise
// - Autoretry: off, wait retry time, retry
// - Autoretry keeps fault low while fault persists
// - Latchoff stays off until enable toggles
// - Continuous mode flags while drop exceeds threshold
// - Reverse blocking only when block enable high
// - Reverse current turns both off 450us
// - Staged re-enable 200us and 1.2ms
// - Output low: re-enable 1.4ms and 2.4ms
// - Reverse event always restarts
// - Slow filtered and fast immediate reverse detectors
// - Fault indicator low on drop, reverse, thermal, lockout, limit pin and autoretry wait
// - Thermal trip turns off and flags
// - Autoretry thermal exit waits retry time
// - Latchoff thermal fault latches until toggle
// - Continuous thermal exit waits debounce time
// - Grounded limit-set pin keeps switch off
// - Switch on unless hv-enable-n high, enable low
`timescale 1ns/100ps
`default_nettype none

module psfc_core
	import psfc_pkg::*;
#(
	parameter int HOLD_CYCLES  = HOLD_CYC,
	parameter int RETRY_CYCLES = RETRY_CYC,
	parameter int STO_CYCLES   = STO_CYC,
	parameter int DEB_CYCLES   = DEB_CYC,
	parameter int EXT_CYCLES   = EXT_ON_CYC,
	parameter int REC_CYCLES   = REV_REC_CYC,
	parameter int OFF_CYCLES   = MIN_OFF_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Comparator and strap pins
	input  wire psfc_sense_s sensePins,
	// Transistor enables and open-drain indicator
	output logic             intFetOn,
	output logic             extFetOn,
	output logic             faultOe,
	output logic             faultOut,
	// AXI4-Lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [3:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]       rstSync;
		psfc_sense_s      s1;
		psfc_sense_s      s2;
		psfc_sense_s      s3;
		psfc_sense_s      sns;      // Agreed pin levels
		logic [1:0]       ctrl;
		logic             enPrev;
		psfc_state_e      st;
		psfc_mode_e       mode;
		logic             modeLocked;
		logic [CNT_W-1:0] stoCnt;
		logic [CNT_W-1:0] holdCnt;
		logic [CNT_W-1:0] tmr;
		logic [CNT_W-1:0] extTmr;
		logic [FLT_W-1:0] revFilt;
		logic             outLowAtRec;
		logic             intOn;
		logic             extOn;
		logic             fault;
		logic             awGot;
		logic [3:0]       awAddr;
		logic             wGot;
		logic [31:0]      wData;
		logic [3:0]       wStrb;
		logic             bValid;
		logic [1:0]       bResp;
		logic             rValid;
		logic [31:0]      rData;
		logic [1:0]       rResp;
	} psfc_core_s;

	psfc_core_s cur_ff;
	psfc_core_s nxt_cur;

	logic rstInt_n;
	assign rstInt_n = cur_ff.rstSync[1];

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic swEnable;
		logic enToggle;
		logic revTrip;
		logic severeTrip;
		logic blank;
		logic [1:0] selPair;
		swEnable   = 1'b0;
		enToggle   = 1'b0;
		revTrip    = 1'b0;
		severeTrip = 1'b0;
		blank      = 1'b0;
		selPair    = 2'h0;
		nxt_cur = cur_ff;

		// Reset release and three-stage pin capture
		nxt_cur.rstSync = {cur_ff.rstSync[0], 1'b1};
		nxt_cur.s1 = sensePins;
		nxt_cur.s2 = cur_ff.s1;
		nxt_cur.s3 = cur_ff.s2;
		nxt_cur.sns = (cur_ff.s2 ~^ cur_ff.s3) & cur_ff.s2 |
			~(cur_ff.s2 ~^ cur_ff.s3) & cur_ff.sns;

		// Enable decode and toggle detection
		swEnable = ~(cur_ff.ctrl[CTRL_HIGH_VOLTAGE_ENABLE_N_N_BIT] & ~cur_ff.ctrl[CTRL_EN_BIT]);
		enToggle = swEnable & ~cur_ff.enPrev;
		nxt_cur.enPrev = swEnable;

		// Mode select, read once after startup timeout
		selPair = {cur_ff.sns.modeSelHigh, cur_ff.sns.modeSelLow};
		if (!cur_ff.modeLocked) begin
			nxt_cur.mode = MODE_CONT;
			if (cur_ff.stoCnt >= CNT_W'(STO_CYCLES - 1)) begin
				nxt_cur.modeLocked = 1'b1;
				case (selPair)
					2'b00:   nxt_cur.mode = MODE_LATCH;
					2'b01:   nxt_cur.mode = MODE_RETRY;
					default: nxt_cur.mode = MODE_CONT;
				endcase
			end else if (cur_ff.st == ST_ON) begin
				nxt_cur.stoCnt = cur_ff.stoCnt + CNT_W'(1);
			end
		end

		// Slow reverse filter and fast path
		if (cur_ff.sns.revSlow) begin
			if (cur_ff.revFilt != FLT_W'(SLOW_REV_CYC))
				nxt_cur.revFilt = cur_ff.revFilt + FLT_W'(1);
		end else begin
			nxt_cur.revFilt = '0;
		end
		revTrip = cur_ff.sns.revBlockEn &
			(cur_ff.sns.revFast | (cur_ff.revFilt == FLT_W'(SLOW_REV_CYC)));

		// Hold timer on overcurrent in retry and latch modes
		if (cur_ff.sns.overCurrent && cur_ff.st == ST_ON && cur_ff.mode != MODE_CONT) begin
			if (cur_ff.holdCnt != CNT_W'(HOLD_CYCLES))
				nxt_cur.holdCnt = cur_ff.holdCnt + CNT_W'(1);
		end else begin
			nxt_cur.holdCnt = '0;
		end
		blank = (cur_ff.holdCnt == CNT_W'(HOLD_CYCLES));
		severeTrip = cur_ff.sns.severeOver;

		// Timer runs down in every timed state
		if (cur_ff.tmr != '0)
			nxt_cur.tmr = cur_ff.tmr - CNT_W'(1);
		if (cur_ff.extTmr != '0)
			nxt_cur.extTmr = cur_ff.extTmr - CNT_W'(1);

		// Fault response state machine
		case (cur_ff.st)
			ST_STARTUP: begin
				nxt_cur.intOn = 1'b0;
				nxt_cur.extOn = 1'b0;
				if (!swEnable || cur_ff.sns.limitShort || cur_ff.sns.underVolt ||
					cur_ff.sns.overVolt) begin
					nxt_cur.tmr = CNT_W'(DEB_CYCLES);
				end else if (cur_ff.tmr == '0) begin
					nxt_cur.st = ST_ON;
				end
			end
			ST_ON: begin
				nxt_cur.intOn = 1'b1;
				nxt_cur.extOn = (cur_ff.extTmr == '0);
				if (revTrip) begin
					nxt_cur.st = ST_REVREC;
					nxt_cur.tmr = CNT_W'(REC_CYCLES);
					nxt_cur.intOn = 1'b0;
					nxt_cur.extOn = 1'b0;
				end else if (cur_ff.sns.overTemp) begin
					nxt_cur.st = (cur_ff.mode == MODE_LATCH) ? ST_LATCHED : ST_THERMAL;
					nxt_cur.intOn = 1'b0;
					nxt_cur.extOn = 1'b0;
				end else if (severeTrip) begin
					nxt_cur.st = ST_SEVERE;
					nxt_cur.tmr = CNT_W'(OFF_CYCLES);
					nxt_cur.intOn = 1'b0;
					nxt_cur.extOn = 1'b0;
				end else if (blank) begin
					nxt_cur.intOn = 1'b0;
					nxt_cur.extOn = 1'b0;
					if (cur_ff.mode == MODE_LATCH) begin
						nxt_cur.st = ST_LATCHED;
					end else begin
						nxt_cur.st = ST_RETRY;
						nxt_cur.tmr = CNT_W'(RETRY_CYCLES);
					end
				end else if (!swEnable || cur_ff.sns.limitShort || cur_ff.sns.underVolt ||
					cur_ff.sns.overVolt) begin
					nxt_cur.st = ST_STARTUP;
					nxt_cur.tmr = CNT_W'(DEB_CYCLES);
					nxt_cur.intOn = 1'b0;
					nxt_cur.extOn = 1'b0;
				end
			end
			ST_SEVERE: begin
				// Off time stretches while severe overload or drop persists
				if (cur_ff.sns.severeOver || cur_ff.sns.dropHigh && !cur_ff.intOn)
					nxt_cur.tmr = (cur_ff.tmr == '0) ? CNT_W'(OFF_CYCLES) : nxt_cur.tmr;
				else if (cur_ff.tmr == '0)
					nxt_cur.st = ST_ON; // restart, hold timer bounds blanking
			end
			ST_RETRY: begin
				if (cur_ff.tmr == '0)
					nxt_cur.st = ST_ON;
			end
			ST_LATCHED: begin
				if (enToggle) begin
					nxt_cur.st = ST_STARTUP;
					nxt_cur.tmr = CNT_W'(DEB_CYCLES);
				end
			end
			ST_REVREC: begin
				if (revTrip) begin
					nxt_cur.tmr = CNT_W'(REC_CYCLES); // monitoring continues
				end else if (cur_ff.tmr == '0) begin
					nxt_cur.st = ST_REVON;
					nxt_cur.outLowAtRec = cur_ff.sns.outBelowUv;
					nxt_cur.tmr = cur_ff.sns.outBelowUv ?
						CNT_W'(DEB_CYCLES + INT_ON_CYC) : CNT_W'(INT_ON_CYC);
					nxt_cur.extTmr = cur_ff.sns.outBelowUv ?
						CNT_W'(DEB_CYCLES + EXT_CYCLES) : CNT_W'(EXT_CYCLES);
				end
			end
			ST_REVON: begin
				if (revTrip) begin
					nxt_cur.st = ST_REVREC;
					nxt_cur.tmr = CNT_W'(REC_CYCLES);
				end else if (cur_ff.tmr == '0) begin
					nxt_cur.st = ST_ON; // external follows its own delay
				end
			end
			ST_THERMAL: begin
				if (cur_ff.sns.underTemp) begin
					nxt_cur.st = ST_RETRY;
					nxt_cur.tmr = (cur_ff.mode == MODE_RETRY) ?
						CNT_W'(RETRY_CYCLES) : CNT_W'(DEB_CYCLES);
				end
			end
			default: nxt_cur.st = ST_STARTUP;
		endcase

		// Fault indicator
		nxt_cur.fault = cur_ff.sns.dropHigh | revTrip |
			(cur_ff.st == ST_REVREC) | cur_ff.sns.overTemp |
			(cur_ff.st == ST_THERMAL) | cur_ff.sns.limitShort |
			cur_ff.sns.underVolt | cur_ff.sns.overVolt |
			((cur_ff.st == ST_RETRY) & (cur_ff.mode == MODE_RETRY));

		// AXI4-Lite write path
		if (s_axi_awvalid && !cur_ff.awGot) begin
			nxt_cur.awGot = 1'b1;
			nxt_cur.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !cur_ff.wGot) begin
			nxt_cur.wGot = 1'b1;
			nxt_cur.wData = s_axi_wdata;
			nxt_cur.wStrb = s_axi_wstrb;
		end
		if (cur_ff.awGot && cur_ff.wGot && !cur_ff.bValid) begin
			nxt_cur.awGot = 1'b0;
			nxt_cur.wGot = 1'b0;
			nxt_cur.bValid = 1'b1;
			nxt_cur.bResp = 2'h0;
			if (cur_ff.awAddr == CTRL_OFS) begin
				if (cur_ff.wStrb[0])
					nxt_cur.ctrl = cur_ff.wData[1:0];
			end else begin
				nxt_cur.bResp = 2'h2;
			end
		end
		if (cur_ff.bValid && s_axi_bready)
			nxt_cur.bValid = 1'b0;

		// AXI4-Lite read path
		if (s_axi_arvalid && !cur_ff.rValid) begin
			nxt_cur.rValid = 1'b1;
			nxt_cur.rResp = 2'h0;
			case (s_axi_araddr)
				CTRL_OFS:   nxt_cur.rData = {30'h0, cur_ff.ctrl};
				STATUS_OFS: nxt_cur.rData = {19'h0, cur_ff.st, cur_ff.mode,
					cur_ff.st == ST_LATCHED, ~cur_ff.fault, cur_ff.intOn};
				SENSE_OFS:  nxt_cur.rData = {18'h0, cur_ff.sns};
				default: begin
					nxt_cur.rData = 32'h0;
					nxt_cur.rResp = 2'h2;
				end
			endcase
		end else if (cur_ff.rValid && s_axi_rready) begin
			nxt_cur.rValid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_ff <= '0;
		end else if (!rstInt_n) begin
			cur_ff <= '0;
			cur_ff.rstSync <= {cur_ff.rstSync[0], 1'b1};
			cur_ff.ctrl <= CTRL_RST;
			cur_ff.st <= ST_STARTUP;
			cur_ff.mode <= MODE_CONT;
			cur_ff.tmr <= CNT_W'(DEB_CYCLES);
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign intFetOn      = cur_ff.intOn;
	assign extFetOn      = cur_ff.extOn;
	assign faultOe       = cur_ff.fault;   // Pull low while a fault stands
	assign faultOut      = 1'b0;
	assign s_axi_awready = ~cur_ff.awGot;
	assign s_axi_wready  = ~cur_ff.wGot;
	assign s_axi_bvalid  = cur_ff.bValid;
	assign s_axi_bresp   = cur_ff.bResp;
	assign s_axi_arready = ~cur_ff.rValid;
	assign s_axi_rvalid  = cur_ff.rValid;
	assign s_axi_rdata   = cur_ff.rData;
	assign s_axi_rresp   = cur_ff.rResp;

endmodule : psfc_core

`default_nettype wire

// ===== psfc_core_props.sv
/* Checker for psfc_core: fault responses and bus handshakes.
 * Assumes it is bound to psfc_core, one clock, arst_n as reset. */
`timescale 1ns/100ps
`default_nettype none
module psfc_core_props
	import psfc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// Pins
	input wire psfc_sense_s sensePins,
	input wire logic        intFetOn,
	input wire logic        extFetOn,
	input wire logic        faultOe,
	input wire logic        faultOut,
	// Bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [3:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [3:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	// ------------------------------------------------------------
	// Settling counter after reset release
	// ------------------------------------------------------------
	logic [3:0] upCnt;

	// Hides input synchroniser fill after reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) upCnt <= 4'h0;
		else if (upCnt != 4'hf) upCnt <= upCnt + 4'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	AST_THERMAL_OFF: assert property ((upCnt == 4'hf && sensePins.overTemp) [*8] |-> !intFetOn && !extFetOn && faultOe)
		else $error("Switch on during over temperature");
	AST_LIMIT_SHORT: assert property ((upCnt == 4'hf && sensePins.limitShort) [*8] |-> !intFetOn && faultOe)
		else $error("Switch on with limit pin grounded");
	AST_DROP_FLAG: assert property ((upCnt == 4'hf && sensePins.dropHigh) [*8] |-> faultOe)
		else $error("No fault flag with high switch drop");
	AST_LOCKOUT_FLAG: assert property ((upCnt == 4'hf && (sensePins.underVolt || sensePins.overVolt)) [*8] |-> faultOe)
		else $error("No fault flag in lockout");
	AST_REV_FAST: assert property ((upCnt == 4'hf && sensePins.revFast && sensePins.revBlockEn) [*8] |-> !intFetOn && !extFetOn)
		else $error("Transistors on during reverse current");
	AST_SEVERE_OFF: assert property ((upCnt == 4'hf && sensePins.severeOver) [*8] |-> !intFetOn && !extFetOn)
		else $error("Transistors on during severe overload");
	AST_MIN_OFF: assert property ($fell(intFetOn) |-> (!intFetOn) [*6])
		else $error("Switch off time too short");
	AST_RD_ONE: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read answer not one cycle after address");
	AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped before taken");
	AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("Write response late");
endmodule : psfc_core_props

bind psfc_core psfc_core_props props_u (
	.clk(clk), .arst_n(arst_n), .sensePins(sensePins), .intFetOn(intFetOn),
	.extFetOn(extFetOn), .faultOe(faultOe), .faultOut(faultOut),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);
`default_nettype wire

// ===== psfc_load_model.sv
/* Load model for the pass transistors of the switch controller.
 * Assumes the bench commands a shorted load on shortLoad. */
`timescale 1ns/100ps
`default_nettype none
module psfc_load_model (
	// Clock
	input  wire logic clk,
	// Transistor enables
	input  wire logic intFetOn,
	input  wire logic extFetOn,
	// Load condition from the bench
	input  wire logic shortLoad,
	// Sensed load state
	output var logic  overCurrent = 1'b0,
	output var logic  dropHigh    = 1'b0,
	output var logic  outBelowUv  = 1'b1
);
	// Output node follows the transistors one cycle later
	always @(posedge clk) begin
		overCurrent <= shortLoad && (intFetOn || extFetOn);
		dropHigh    <= shortLoad && (intFetOn || extFetOn);
		outBelowUv  <= !(intFetOn || extFetOn); // Output collapses when off
	end
endmodule : psfc_load_model
`default_nettype wire

// ===== psfc_pkg.sv
/*
 * Package for the power switch fault controller: register map, field
 * positions, reset values, timing figures and the carrier structs.
 * Assumes a 50 MHz clock; times are given in microseconds.
 */
package psfc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ            = 50;
	localparam int MIN_OFF_US         = 420;     // Least off time after severe overload
	localparam int REV_REC_US         = 450;     // Reverse recovery interval
	localparam int INT_ON_US          = 200;     // Internal transistor re-enable delay
	localparam int EXT_ON_US          = 1200;    // External transistor re-enable delay
	localparam int DEB_US             = 1200;    // Power-on debounce time
	localparam int HOLD_US            = 24000;   // Overcurrent hold time
	localparam int RETRY_US           = 720000;  // Restart wait time
	localparam int STO_US             = 1090000; // Startup timeout
	localparam int SLOW_REV_US        = 30;      // Slow reverse detector, longest response
	localparam int MIN_OFF_CYC        = MIN_OFF_US * CLK_MHZ;
	localparam int REV_REC_CYC        = REV_REC_US * CLK_MHZ;
	localparam int INT_ON_CYC         = INT_ON_US * CLK_MHZ;
	localparam int EXT_ON_CYC         = EXT_ON_US * CLK_MHZ;
	localparam int DEB_CYC            = DEB_US * CLK_MHZ;
	localparam int HOLD_CYC           = HOLD_US * CLK_MHZ;
	localparam int RETRY_CYC          = RETRY_US * CLK_MHZ;
	localparam int STO_CYC            = STO_US * CLK_MHZ;
	localparam int SLOW_REV_CYC       = (SLOW_REV_US * CLK_MHZ) / 2; // Filter length, half bound
	localparam int CNT_W              = 26;
	localparam int FLT_W              = 10;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] SENSE_OFS  = 4'h8;

	// Control fields
	localparam int CTRL_EN_BIT        = 0;   // Active-high enable
	localparam int CTRL_HIGH_VOLTAGE_ENABLE_N_N_BIT    = 1;   // Active-low high-voltage enable
	localparam logic [1:0] CTRL_RST   = 2'h1;

	// Status fields
	localparam int ST_SW_BIT          = 0;
	localparam int ST_FLAG_BIT        = 1;
	localparam int ST_LATCH_BIT       = 2;
	localparam int ST_MODE_LSB        = 3;
	localparam int ST_STATE_LSB       = 5;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_LATCH = 2'h0,
		MODE_RETRY = 2'h1,
		MODE_CONT  = 2'h2
	} psfc_mode_e;

	typedef enum logic [7:0] {
		ST_STARTUP = 8'h01,
		ST_ON      = 8'h02,
		ST_SEVERE  = 8'h04,
		ST_RETRY   = 8'h08,
		ST_LATCHED = 8'h10,
		ST_REVREC  = 8'h20,
		ST_REVON   = 8'h40,
		ST_THERMAL = 8'h80
	} psfc_state_e;

	typedef struct packed {
		logic overCurrent;    // Current at programmed limit
		logic severeOver;     // Current above twice the limit
		logic dropHigh;       // Switch drop above fault threshold
		logic revSlow;        // Slow reverse comparator
		logic revFast;        // Fast reverse comparator
		logic overTemp;       // Above rising thermal threshold
		logic underTemp;      // Below falling thermal threshold
		logic underVolt;      // Undervoltage lockout active
		logic overVolt;       // Overvoltage lockout active
		logic limitShort;     // Limit-set pin grounded
		logic outBelowUv;     // Output below undervoltage level
		logic modeSelHigh;
		logic modeSelLow;
		logic revBlockEn;
	} psfc_sense_s;

	typedef struct packed {
		logic intFetOn;
		logic extFetOn;
		logic faultN;
	} psfc_drive_s;

endpackage : psfc_pkg

// ===== testbench.sv
/* Self-checking bench for psfc_core with a load model.
 * Assumes shortened timer parameters; slow filter and 200us delay fixed. */
`timescale 1ns/100ps
`default_nettype none
module testbench
	import psfc_pkg::*;
;
	logic        clk = 1'b0;
	logic        arst_n;
	psfc_sense_s tbSense, senseBus;
	logic        shortLoad, ldOver, ldDrop, ldBelow, intFetOn, extFetOn, faultOe, faultOut;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic        rvalid, rready;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	wire logic   flagPin;
	int          fails = 0;
	int          totalChecks = 0;

	always #10 clk = ~clk;
	assign flagPin = faultOe ? faultOut : 1'b1; // Pull-up on the indicator

	// Load model outputs replace the bench's own sense bits
	always_comb begin
		senseBus = tbSense;
		senseBus.overCurrent = ldOver;
		senseBus.dropHigh = ldDrop;
		senseBus.outBelowUv = ldBelow;
	end

	psfc_load_model load_u (.clk(clk), .intFetOn(intFetOn), .extFetOn(extFetOn),
		.shortLoad(shortLoad), .overCurrent(ldOver), .dropHigh(ldDrop), .outBelowUv(ldBelow));

	psfc_core #(.HOLD_CYCLES(20), .RETRY_CYCLES(40), .STO_CYCLES(60), .DEB_CYCLES(10),
		.EXT_CYCLES(12), .REC_CYCLES(9), .OFF_CYCLES(8)) dut_u (
		.clk(clk), .arst_n(arst_n), .sensePins(senseBus), .intFetOn(intFetOn),
		.extFetOn(extFetOn), .faultOe(faultOe), .faultOut(faultOut),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("checks=%0d mismatches=%0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk); // Gap edge keeps back-to-back calls apart
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		r = bresp;
		bready <= 1'b0;
		check(n < 200, 1'b1);
	endtask : axiWrite

	task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk); // Gap edge keeps back-to-back calls apart
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		check(n < 200, 1'b1);
	endtask : axiRead

	task automatic waitOn(input logic want, input int lim);
		int n;
		n = 0;
		while (intFetOn !== want && n < lim) begin
			@(posedge clk);
			n++;
		end
		check(intFetOn, want);
	endtask : waitOn

	task automatic heat(input logic hot);
		tbSense.overTemp <= hot;
		tbSense.underTemp <= !hot;
	endtask : heat

	// Watchdog
	initial begin
		#2_000_000;
		fails++;
		test_done();
	end

	// ------------------------------------------------------------
	// Main sequence, one pass per select code
	// ------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic [1:0]  rs;
		tbSense = '0;
		tbSense.underTemp = 1'b1;
		tbSense.revBlockEn = 1'b1;
		{shortLoad, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		arst_n = 1'b0;
		for (int m = 0; m < 4; m++) begin
			tbSense.modeSelHigh <= m[1];
			tbSense.modeSelLow <= m[0];
			arst_n <= 1'b0;
			repeat (2) @(posedge clk);
			arst_n <= 1'b1;
			repeat (4) @(posedge clk);
			axiRead(STATUS_OFS, rd, rs);
			check(rd[4:3], 2'h2);
			waitOn(1'b1, 20000);
			repeat (200) @(posedge clk);
			axiRead(STATUS_OFS, rd, rs);
			check(rd[4:3], m[1] ? 2'h2 : m[1:0]);
			case (m)
				0: begin
					axiRead(CTRL_OFS, rd, rs);
					check(rd, 32'h1);
					axiRead(4'hc, rd, rs);
					check(rd, 32'h0);
					check(rs, 2'h2);
					axiWrite(STATUS_OFS, 32'h0, rs);
					check(rs, 2'h2);
					wstrb <= 4'he;
					axiWrite(CTRL_OFS, 32'h2, rs);
					wstrb <= 4'hf;
					check(rs, 2'h0);
					axiRead(CTRL_OFS, rd, rs);
					check(rd, 32'h1);
					shortLoad <= 1'b1;
					repeat (8) @(posedge clk);
					shortLoad <= 1'b0;
					repeat (30) @(posedge clk);
					check(intFetOn, 1'b1);
					shortLoad <= 1'b1;
					waitOn(1'b0, 100);
					shortLoad <= 1'b0;
					repeat (100) @(posedge clk);
					axiRead(STATUS_OFS, rd, rs);
					check({intFetOn, rd[2]}, 2'h1);
					axiWrite(CTRL_OFS, 32'h2, rs);
					axiWrite(CTRL_OFS, 32'h1, rs);
					waitOn(1'b1, 20000);
					heat(1'b1);
					waitOn(1'b0, 20);
					heat(1'b0);
					repeat (200) @(posedge clk);
					check(intFetOn, 1'b0);
				end
				1: begin
					shortLoad <= 1'b1;
					waitOn(1'b0, 100);
					repeat (30) @(posedge clk);
					check({intFetOn, flagPin}, 2'h0);
					waitOn(1'b1, 100);
					waitOn(1'b0, 100);
					check(flagPin, 1'b0);
					shortLoad <= 1'b0;
					waitOn(1'b1, 200);
					repeat (100) @(posedge clk);
					check(intFetOn, 1'b1);
					heat(1'b1);
					waitOn(1'b0, 20);
					check(flagPin, 1'b0);
					heat(1'b0);
					repeat (25) @(posedge clk);
					check(intFetOn, 1'b0);
					waitOn(1'b1, 200);
				end
				2: begin
					shortLoad <= 1'b1;
					repeat (100) @(posedge clk);
					check({intFetOn, flagPin}, 2'h2);
					shortLoad <= 1'b0;
					repeat (10) @(posedge clk);
					check(flagPin, 1'b1);
					heat(1'b1);
					waitOn(1'b0, 20);
					heat(1'b0);
					waitOn(1'b1, 50);
					tbSense.revFast <= 1'b1;
					waitOn(1'b0, 10);
					tbSense.revFast <= 1'b0;
					repeat (9000) @(posedge clk);
					check({intFetOn, extFetOn}, 2'h0);
					waitOn(1'b1, 3000);
					repeat (200) @(posedge clk);
					check(extFetOn, 1'b1);
					tbSense.revBlockEn <= 1'b0;
					tbSense.revFast <= 1'b1;
					repeat (50) @(posedge clk);
					check(intFetOn, 1'b1);
					tbSense.revFast <= 1'b0;
					tbSense.revBlockEn <= 1'b1;
					tbSense.revSlow <= 1'b1;
					waitOn(1'b0, 1000);
					tbSense.revSlow <= 1'b0;
					waitOn(1'b1, 12000);
				end
				default: begin
					tbSense.severeOver <= 1'b1;
					waitOn(1'b0, 10);
					tbSense.severeOver <= 1'b0;
					waitOn(1'b1, 12000);
					tbSense.limitShort <= 1'b1;
					waitOn(1'b0, 20);
					check(flagPin, 1'b0);
					tbSense.limitShort <= 1'b0;
					waitOn(1'b1, 12000);
					tbSense.underVolt <= 1'b1;
					repeat (20) @(posedge clk);
					check(flagPin, 1'b0);
					tbSense.underVolt <= 1'b0;
					waitOn(1'b1, 12000);
					tbSense.overVolt <= 1'b1;
					waitOn(1'b0, 20);
					check(flagPin, 1'b0);
					tbSense.overVolt <= 1'b0;
					waitOn(1'b1, 12000);
				end
			endcase
		end
		test_done();
	end
endmodule : testbench
`default_nettype wire
